/* scmc_deser_model.sv */
// paired deserializer model supplying the back-channel reference ticks
`timescale 1ns/1ps
module scmc_deser_model #(
  parameter int PERIOD = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link up
  input wire logic en,
  // back-channel reference
  output logic bc_ref_tick
);
  int cnt;
  // reference only runs while the link is up, never mid-reset
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      cnt <= 0;
      bc_ref_tick <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      bc_ref_tick <= (cnt == 0);
    end
  end
endmodule

/* scmc_frac_div.sv */
// fractional divider producing the sensor reference clock level
`timescale 1ns/1ps
module scmc_frac_div #(
  parameter int MW = 5,
  parameter int NW = 8,
  parameter int DW = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic en,
  input wire logic tick,
  input wire logic [MW-1:0] mult,
  input wire logic [NW-1:0] ndiv,
  input wire logic [DW-1:0] prediv,
  // output
  output logic clk_lvl,
  output logic clk_edge
);

  localparam int AW = NW + DW + 1;

  typedef struct packed {
    logic [AW-1:0] acc;
    logic lvl;
    logic edge_p;
  } scmc_div_s;

  scmc_div_s cs;
  scmc_div_s nx;
  logic [AW-1:0] limit;
  logic [AW-1:0] sum;

  // each toggle is half a period, so step by twice the multiplier
  always_comb begin
    nx = cs;
    nx.edge_p = 1'b0;
    limit = AW'(prediv) * AW'(ndiv);
    sum = cs.acc + AW'({mult, 1'b0});
    if (!en || (limit == '0)) begin
      nx.acc = '0;
      nx.lvl = 1'b0;
    end else if (tick) begin
      // integer ndiv/mult toggles on a fixed count, otherwise dithers
      if (sum >= limit) begin
        nx.acc = sum - limit;
        nx.lvl = !cs.lvl;
        nx.edge_p = 1'b1;
      end else begin
        nx.acc = sum;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs <= '0;
    end else begin
      cs <= nx;
    end
  end

  assign clk_lvl = cs.lvl;
  assign clk_edge = cs.edge_p;

endmodule

/* scmc_mode_ctrl.sv */
// clocking mode selection, reference mux and compat configuration
`timescale 1ns/1ps
// What this block does
// - synchronous mode uses the back-channel clock for link and sensor clock.
// - external clock mode derives link and sensor clock from external input.
// - internal mode uses the always-on oscillator as link reference.
// - sensor clock output is disabled in internal oscillator mode.
// - mode field 0x03[2:0] always shows the current operating mode.
// - mode field writable only while override bit 4 is one.
// - strap value captured into mode field on power-down input rising.
// - mode codes are 0 sync, 2 ext, 3 internal, 5 parallel compat.
// - override plus write of 101 selects parallel compat external mode.
// - sensor clock is rate times M over predivider times N, rate-limited.
// - integer N/M gives clean output, otherwise dithered jitter.
// - register 0x04 overrides compat pixel format to raw10 or raw12.
// - register 0x10 chooses long, YUV and typed packets in compat mode.
// - type filter enable accepts packets whose type matches register 0x11.
// - raw12 low-frequency format is unsupported; raw10 and raw12 HF only.
module scmc_mode_ctrl #(
  parameter logic DEFAULT_RAW12 = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access
  input scmc_pkg::scmc_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // power-down and strap
  input wire logic power_down_input,
  input wire logic [2:0] mode_strap,
  // reference sources as one-cycle ticks, and the forward rate in MHz
  input wire logic bc_ref_tick,
  input wire logic ext_ref_tick,
  input wire logic osc_ref_tick,
  input wire logic [15:0] fc_rate_mhz,
  // forward channel reference, live mode and oscillator rate setting
  output logic fc_ref_tick,
  output logic [2:0] op_mode,
  output logic internal_osc_full_rate,
  // sensor reference clock
  output logic sensor_clk,
  output logic sensor_clk_edge,
  output logic sensor_clk_oe,
  output logic rate_err,
  // parallel compat packet filter
  output logic parallel_compat_mode,
  output logic compat_raw12,
  input scmc_pkg::scmc_pkt_s pkt_in,
  output logic pkt_accept,
  output logic pkt_accept_valid
);

  typedef struct packed {
    logic [2:0] mode;
    logic ovr;
    logic osc_full;
    logic fmt_ovr;
    logic fmt_raw12;
    logic [4:0] m;
    logic [1:0] div_code;
    logic [7:0] n;
    logic [7:0] pcfg;
    logic [7:0] ptype;
    logic pdb_q;
    logic [7:0] rdata;
    logic rvalid;
    logic fc_tick;
    logic oe;
    logic rate_err;
    logic acc;
    logic acc_valid;
  } scmc_regs_s;

  scmc_regs_s cs;
  scmc_regs_s nx;
  logic [4:0] prediv;
  logic [15:0] rate_limit;
  logic raw12_sel;
  logic pkt_hit;

  assign prediv = scmc_pkg::div_value(cs.div_code);
  assign raw12_sel = cs.fmt_ovr ? cs.fmt_raw12 : DEFAULT_RAW12;

  always_comb begin
    nx = cs;
    nx.rvalid = 1'b0;
    nx.acc_valid = 1'b0;
    nx.pdb_q = power_down_input;
    rate_limit = 16'(prediv) * scmc_pkg::FC_DIV_LIMIT_MHZ;
    pkt_hit = 1'b0;

    if (reg_req.wr) begin
      unique case (reg_req.addr)
        scmc_pkg::ADDR_MODE: begin
          nx.ovr = reg_req.wdata[scmc_pkg::MODE_OVR_BIT];
          // the override bit of the same write unlocks the field
          if (reg_req.wdata[scmc_pkg::MODE_OVR_BIT] &&
              scmc_pkg::mode_legal(reg_req.wdata[2:0])) begin
            nx.mode = reg_req.wdata[2:0];
          end
        end
        scmc_pkg::ADDR_FMT: begin
          nx.fmt_ovr = reg_req.wdata[scmc_pkg::FMT_OVR_BIT];
          // only raw10 or raw12 HF can be chosen
          nx.fmt_raw12 = reg_req.wdata[scmc_pkg::FMT_RAW12_BIT];
        end
        scmc_pkg::ADDR_OSC: begin
          nx.osc_full = reg_req.wdata[scmc_pkg::OSC_FULL_BIT];
        end
        scmc_pkg::ADDR_CLKCFG: begin
          nx.m = reg_req.wdata[scmc_pkg::CLK_M_LSB +: scmc_pkg::CLK_M_W];
          nx.div_code = reg_req.wdata[scmc_pkg::CLK_DIV_LSB +: 2];
        end
        scmc_pkg::ADDR_CLKN: begin
          nx.n = reg_req.wdata;
        end
        scmc_pkg::ADDR_PCFG: begin
          nx.pcfg = reg_req.wdata;
        end
        scmc_pkg::ADDR_PTYPE: begin
          nx.ptype = reg_req.wdata;
        end
        default: begin
        end
      endcase
    end

    // strap capture wins over a register write in the same cycle
    if (power_down_input && !cs.pdb_q) begin
      nx.mode = mode_strap;
    end

    if (reg_req.rd) begin
      nx.rvalid = 1'b1;
      unique case (reg_req.addr)
        scmc_pkg::ADDR_MODE: nx.rdata = {3'h0, cs.ovr, 1'b0, cs.mode};
        scmc_pkg::ADDR_FMT: nx.rdata = {6'h00, cs.fmt_raw12, cs.fmt_ovr};
        scmc_pkg::ADDR_OSC: nx.rdata = {4'h0, cs.osc_full, 3'h0};
        scmc_pkg::ADDR_CLKCFG: nx.rdata = {1'b0, cs.div_code, cs.m};
        scmc_pkg::ADDR_CLKN: nx.rdata = cs.n;
        scmc_pkg::ADDR_PCFG: nx.rdata = cs.pcfg;
        scmc_pkg::ADDR_PTYPE: nx.rdata = cs.ptype;
        default: nx.rdata = 8'h00;
      endcase
    end

    // reference mux follows the live mode field
    unique case (cs.mode)
      scmc_pkg::MODE_SYNC: nx.fc_tick = bc_ref_tick;
      scmc_pkg::MODE_EXT: nx.fc_tick = ext_ref_tick;
      scmc_pkg::MODE_INT: nx.fc_tick = osc_ref_tick;
      scmc_pkg::MODE_COMPAT: nx.fc_tick = ext_ref_tick;
      default: nx.fc_tick = 1'b0;
    endcase

    // divider output at or above the limit is unusable, so the pin is dropped
    nx.rate_err = fc_rate_mhz >= rate_limit;
    nx.oe = (cs.mode != scmc_pkg::MODE_INT) && (cs.mode != 3'h1) &&
            !nx.rate_err && scmc_pkg::mode_legal(cs.mode);

    if (pkt_in.valid) begin
      nx.acc_valid = 1'b1;
      if (cs.mode == scmc_pkg::MODE_COMPAT) begin
        if (cs.pcfg[scmc_pkg::PCFG_DTEN_BIT] &&
            (pkt_in.dt == cs.ptype[5:0])) begin
          pkt_hit = 1'b1;
        end
        if (pkt_in.dt == (raw12_sel ? scmc_pkg::DT_RAW12 :
                                      scmc_pkg::DT_RAW10)) begin
          pkt_hit = 1'b1;
        end
        if (cs.pcfg[scmc_pkg::PCFG_YUV_BIT] &&
            (pkt_in.dt >= scmc_pkg::DT_YUV_LO) &&
            (pkt_in.dt <= scmc_pkg::DT_YUV_HI)) begin
          pkt_hit = 1'b1;
        end
        if (cs.pcfg[scmc_pkg::PCFG_LONG_BIT] &&
            (pkt_in.dt >= scmc_pkg::DT_LONG_LO)) begin
          pkt_hit = 1'b1;
        end
        nx.acc = pkt_hit;
      end else begin
        // outside compat mode the filter is transparent
        nx.acc = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs <= '0;
      cs.mode <= scmc_pkg::MODE_RST;
      cs.m <= scmc_pkg::M_RST;
      cs.div_code <= scmc_pkg::DIV_CODE_RST;
      cs.n <= scmc_pkg::N_RST;
      cs.pcfg <= scmc_pkg::PCFG_RST;
      cs.ptype <= scmc_pkg::PTYPE_RST;
      cs.pdb_q <= scmc_pkg::PDB_RST; // no false capture after reset
    end else begin
      cs <= nx;
    end
  end

  // sensor clock runs on the same selected reference as the link
  scmc_frac_div #(
    .MW(5),
    .NW(8),
    .DW(5)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .en(cs.oe),
    .tick(cs.fc_tick),
    .mult(cs.m),
    .ndiv(cs.n),
    .prediv(prediv),
    .clk_lvl(sensor_clk),
    .clk_edge(sensor_clk_edge)
  );

  assign reg_rdata = cs.rdata;
  assign reg_rvalid = cs.rvalid;
  assign fc_ref_tick = cs.fc_tick;
  assign op_mode = cs.mode;
  assign internal_osc_full_rate = cs.osc_full;
  assign sensor_clk_oe = cs.oe;
  assign rate_err = cs.rate_err;
  assign parallel_compat_mode = cs.mode == scmc_pkg::MODE_COMPAT;
  assign compat_raw12 = raw12_sel;
  assign pkt_accept = cs.acc;
  assign pkt_accept_valid = cs.acc_valid;

  logic pdb_rise;
  assign pdb_rise = power_down_input && !cs.pdb_q;

  a_sync_ref_src: assert property (
    @(posedge clk) disable iff (rst)
    (cs.mode == scmc_pkg::MODE_SYNC) |=> fc_ref_tick == $past(bc_ref_tick))
    else $error("sync mode not on back-channel reference");

  a_ext_ref_src: assert property (
    @(posedge clk) disable iff (rst)
    ((cs.mode == scmc_pkg::MODE_EXT) || (cs.mode == scmc_pkg::MODE_COMPAT))
    |=> fc_ref_tick == $past(ext_ref_tick))
    else $error("external mode not on external reference");

  a_int_ref_src: assert property (
    @(posedge clk) disable iff (rst)
    (cs.mode == scmc_pkg::MODE_INT) |=> fc_ref_tick == $past(osc_ref_tick))
    else $error("internal mode not on oscillator");

  a_int_clk_off: assert property (
    @(posedge clk) disable iff (rst)
    (cs.mode == scmc_pkg::MODE_INT) [*2] |=> !sensor_clk_oe && !sensor_clk)
    else $error("sensor clock active in internal mode");

  a_strap_capture: assert property (
    @(posedge clk) disable iff (rst)
    pdb_rise |=> op_mode == $past(mode_strap))
    else $error("strap not captured on power-down release");

  a_mode_locked: assert property (
    @(posedge clk) disable iff (rst)
    (reg_req.wr && !reg_req.wdata[scmc_pkg::MODE_OVR_BIT] && !pdb_rise)
    |=> $stable(op_mode))
    else $error("mode changed without override");

  a_override_compat: assert property (
    @(posedge clk) disable iff (rst)
    (reg_req.wr && (reg_req.addr == scmc_pkg::ADDR_MODE) &&
     (reg_req.wdata == 8'h15) && !pdb_rise)
    |=> parallel_compat_mode ##1 fc_ref_tick == $past(ext_ref_tick))
    else $error("override to compat mode failed");

  a_mode_readback: assert property (
    @(posedge clk) disable iff (rst)
    (reg_req.rd && (reg_req.addr == scmc_pkg::ADDR_MODE))
    |=> reg_rvalid && (reg_rdata[2:0] == $past(op_mode)))
    else $error("mode field read back wrong");

  a_type_match: assert property (
    @(posedge clk) disable iff (rst)
    (pkt_in.valid && parallel_compat_mode &&
     cs.pcfg[scmc_pkg::PCFG_DTEN_BIT] && (pkt_in.dt == cs.ptype[5:0]))
    |=> pkt_accept_valid && pkt_accept)
    else $error("matching type packet dropped");

  a_rate_limit: assert property (
    @(posedge clk) disable iff (rst)
    (fc_rate_mhz >= 16'(prediv) * scmc_pkg::FC_DIV_LIMIT_MHZ)
    |=> rate_err && !sensor_clk_oe)
    else $error("sensor clock kept past the rate limit");

  a_illegal_code: assert property (
    @(posedge clk) disable iff (rst)
    (reg_req.wr && (reg_req.addr == scmc_pkg::ADDR_MODE) &&
     reg_req.wdata[scmc_pkg::MODE_OVR_BIT] &&
     !scmc_pkg::mode_legal(reg_req.wdata[2:0]) && !pdb_rise)
    |=> $stable(op_mode))
    else $error("illegal mode code accepted");

  a_raw_format: assert property (
    @(posedge clk) disable iff (rst)
    (pkt_in.valid && parallel_compat_mode &&
     (pkt_in.dt == (compat_raw12 ? scmc_pkg::DT_RAW12 :
                                   scmc_pkg::DT_RAW10)))
    |=> pkt_accept_valid && pkt_accept)
    else $error("base format packet dropped");

  a_pkt_answer: assert property (
    @(posedge clk) disable iff (rst)
    pkt_in.valid
    |=> pkt_accept_valid && ($past(parallel_compat_mode) || pkt_accept))
    else $error("packet header left without a verdict");

  c_override_write: cover property (
    @(posedge clk) disable iff (rst)
    reg_req.wr && (reg_req.addr == scmc_pkg::ADDR_MODE) &&
    reg_req.wdata[scmc_pkg::MODE_OVR_BIT]);

  c_strap_release: cover property (
    @(posedge clk) disable iff (rst) pdb_rise);

  c_sensor_edge: cover property (
    @(posedge clk) disable iff (rst) sensor_clk_oe && sensor_clk_edge);

  c_compat_accept: cover property (
    @(posedge clk) disable iff (rst)
    pkt_accept_valid && pkt_accept && parallel_compat_mode);

  c_rate_error: cover property (
    @(posedge clk) disable iff (rst) rate_err && !sensor_clk_oe);

endmodule

/* scmc_pkg.sv */
// shared constants and carriers for the serializer clock mode control
package scmc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_MODE = 8'h03;
  localparam logic [7:0] ADDR_FMT = 8'h04;
  localparam logic [7:0] ADDR_OSC = 8'h05;
  localparam logic [7:0] ADDR_CLKCFG = 8'h06;
  localparam logic [7:0] ADDR_CLKN = 8'h07;
  localparam logic [7:0] ADDR_PCFG = 8'h10;
  localparam logic [7:0] ADDR_PTYPE = 8'h11;

  // mode codes
  localparam logic [2:0] MODE_SYNC = 3'h0;
  localparam logic [2:0] MODE_EXT = 3'h2;
  localparam logic [2:0] MODE_INT = 3'h3;
  localparam logic [2:0] MODE_COMPAT = 3'h5;

  // field positions
  localparam int MODE_OVR_BIT = 4;
  localparam int OSC_FULL_BIT = 3;
  localparam int FMT_OVR_BIT = 0;
  localparam int FMT_RAW12_BIT = 1;
  localparam int CLK_M_LSB = 0;
  localparam int CLK_M_W = 5;
  localparam int CLK_DIV_LSB = 5;
  localparam int PCFG_LONG_BIT = 0;
  localparam int PCFG_YUV_BIT = 1;
  localparam int PCFG_DTEN_BIT = 2;

  // reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [4:0] M_RST = 5'h01;
  localparam logic [1:0] DIV_CODE_RST = 2'h0;
  localparam logic [7:0] N_RST = 8'h01;
  localparam logic [7:0] PCFG_RST = 8'h00;
  localparam logic [7:0] PTYPE_RST = 8'h00;
  // pin idles high while running
  localparam logic PDB_RST = 1'b1;

  // predivider codes 0,1,2 give 4,8,16
  localparam logic [4:0] DIV_4 = 5'h04;
  localparam logic [4:0] DIV_8 = 5'h08;
  localparam logic [4:0] DIV_16 = 5'h10;

  // forward rate over predivider must stay below this
  localparam logic [15:0] FC_DIV_LIMIT_MHZ = 16'h041A;

  // packet data types
  localparam logic [5:0] DT_RAW10 = 6'h2B;
  localparam logic [5:0] DT_RAW12 = 6'h2C;
  localparam logic [5:0] DT_YUV_LO = 6'h18;
  localparam logic [5:0] DT_YUV_HI = 6'h1F;
  localparam logic [5:0] DT_LONG_LO = 6'h10;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scmc_reg_req_s;

  typedef struct packed {
    logic valid;
    logic [5:0] dt;
  } scmc_pkt_s;

  function automatic logic mode_legal(input logic [2:0] m);
    return (m == MODE_SYNC) || (m == MODE_EXT) || (m == MODE_INT) ||
           (m == MODE_COMPAT);
  endfunction

  function automatic logic [4:0] div_value(input logic [1:0] code);
    unique case (code)
      2'h1: return DIV_8;
      2'h2: return DIV_16;
      default: return DIV_4;
    endcase
  endfunction

endpackage

/* tb_top.sv */
// self-checking bench for the serializer clock mode control
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  scmc_pkg::scmc_reg_req_s reg_req = '0;
  scmc_pkg::scmc_pkt_s pkt_in = '0;
  logic power_down_input = 1'b1;
  logic [2:0] mode_strap = 3'h0;
  logic ext_ref_tick = 1'b0;
  logic osc_ref_tick = 1'b0;
  logic [15:0] fc_rate_mhz = 16'h03E8;
  logic src_en = 1'b0;
  logic cnt_clr = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] op_mode;
  logic reg_rvalid, bc_ref_tick, fc_ref_tick, internal_osc_full_rate;
  logic sensor_clk, sensor_clk_edge, sensor_clk_oe, rate_err;
  logic parallel_compat_mode, compat_raw12, pkt_accept, pkt_accept_valid;
  int fails = 0;
  int n_tests = 0;
  int ph = 0;
  int n_bc, n_ext, n_osc, n_fc, n_edge;

  initial begin
    forever #5 clk = ~clk;
  end

  scmc_deser_model #(.PERIOD(4)) partner (.clk(clk), .rst(rst), .en(src_en),
    .bc_ref_tick(bc_ref_tick));

  scmc_mode_ctrl uut (.clk(clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .power_down_input(power_down_input), .mode_strap(mode_strap),
    .bc_ref_tick(bc_ref_tick), .ext_ref_tick(ext_ref_tick),
    .osc_ref_tick(osc_ref_tick), .fc_rate_mhz(fc_rate_mhz),
    .fc_ref_tick(fc_ref_tick), .op_mode(op_mode),
    .internal_osc_full_rate(internal_osc_full_rate),
    .sensor_clk(sensor_clk), .sensor_clk_edge(sensor_clk_edge),
    .sensor_clk_oe(sensor_clk_oe), .rate_err(rate_err),
    .parallel_compat_mode(parallel_compat_mode),
    .compat_raw12(compat_raw12), .pkt_in(pkt_in), .pkt_accept(pkt_accept),
    .pkt_accept_valid(pkt_accept_valid));

  // coprime periods so a wrong source shows up as a wrong count
  always @(negedge clk) begin
    ph <= ph + 1;
    ext_ref_tick <= src_en && (ph % 5 == 0);
    osc_ref_tick <= src_en && (ph % 7 == 0);
  end

  always @(posedge clk) begin
    if (cnt_clr) begin
      n_bc <= 0;
      n_ext <= 0;
      n_osc <= 0;
      n_fc <= 0;
      n_edge <= 0;
    end else begin
      n_bc <= n_bc + int'(bc_ref_tick);
      n_ext <= n_ext + int'(ext_ref_tick);
      n_osc <= n_osc + int'(osc_ref_tick);
      n_fc <= n_fc + int'(fc_ref_tick);
      n_edge <= n_edge + int'(sensor_clk_edge);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge clk);
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge clk);
    reg_req.rd = 1'b0;
    chk(32'(reg_rvalid), 32'h1);
    chk(32'(reg_rdata), 32'(exp));
  endtask

  // headers two clocks apart, on the references' own clock
  task automatic pkt(input logic [5:0] dt, input logic exp);
    @(negedge clk);
    pkt_in.valid = 1'b1;
    pkt_in.dt = dt;
    @(negedge clk);
    pkt_in.valid = 1'b0;
    chk(32'(pkt_accept_valid), 32'h1);
    chk(32'(pkt_accept), 32'(exp));
  endtask

  // all sources run for a while, then settle so every count is complete
  task automatic window;
    @(negedge clk);
    cnt_clr = 1'b1;
    @(negedge clk);
    cnt_clr = 1'b0;
    src_en = 1'b1;
    repeat (40) @(negedge clk);
    src_en = 1'b0;
    repeat (5) @(negedge clk);
  endtask

  task automatic t_sensor;
    window();
    chk(32'(n_bc > 0), 32'h1);
    chk(n_fc, n_bc);
    chk(n_edge, n_fc / 2);
    chk(32'(sensor_clk_oe), 32'h1);
    pkt(6'h05, 1'b1);
  endtask

  task automatic t_rate;
    @(negedge clk);
    fc_rate_mhz = 16'h1067;
    repeat (3) @(negedge clk);
    chk(32'(rate_err), 32'h0);
    fc_rate_mhz = 16'h1068;
    repeat (3) @(negedge clk);
    chk(32'(rate_err), 32'h1);
    chk(32'(sensor_clk_oe), 32'h0);
    fc_rate_mhz = 16'h03E8;
    repeat (3) @(negedge clk);
  endtask

  // predivider codes: edge spacing and the rate limit both scale
  task automatic t_clkcfg;
    wr(scmc_pkg::ADDR_CLKCFG, 8'h21);
    rd(scmc_pkg::ADDR_CLKCFG, 8'h21);
    rd(scmc_pkg::ADDR_CLKN, 8'h01);
    window();
    chk(32'(n_fc > 0), 32'h1);
    chk(n_edge, n_fc / 4);
    @(negedge clk);
    fc_rate_mhz = 16'h20CF;
    repeat (3) @(negedge clk);
    chk(32'(rate_err), 32'h0);
    fc_rate_mhz = 16'h20D0;
    repeat (3) @(negedge clk);
    chk(32'(rate_err), 32'h1);
    wr(scmc_pkg::ADDR_CLKCFG, 8'h41);
    repeat (2) @(negedge clk);
    chk(32'(rate_err), 32'h0);
    wr(scmc_pkg::ADDR_CLKCFG, 8'h61);
    repeat (2) @(negedge clk);
    chk(32'(rate_err), 32'h1);
    fc_rate_mhz = 16'h03E8;
    wr(scmc_pkg::ADDR_CLKCFG, 8'h01);
    repeat (3) @(negedge clk);
    chk(32'(sensor_clk_oe), 32'h1);
  endtask

  task automatic t_strap;
    @(negedge clk);
    power_down_input = 1'b0;
    mode_strap = scmc_pkg::MODE_EXT;
    @(negedge clk);
    power_down_input = 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(op_mode), 32'(scmc_pkg::MODE_EXT));
    rd(scmc_pkg::ADDR_MODE, 8'h02);
    window();
    chk(n_fc, n_ext);
    wr(scmc_pkg::ADDR_MODE, 8'h03);
    chk(32'(op_mode), 32'(scmc_pkg::MODE_EXT));
    rd(scmc_pkg::ADDR_MODE, 8'h02);
  endtask

  task automatic t_override;
    wr(scmc_pkg::ADDR_MODE, 8'h13);
    chk(32'(op_mode), 32'(scmc_pkg::MODE_INT));
    rd(scmc_pkg::ADDR_MODE, 8'h13);
    wr(scmc_pkg::ADDR_OSC, 8'h08);
    chk(32'(internal_osc_full_rate), 32'h1);
    rd(scmc_pkg::ADDR_OSC, 8'h08);
    window();
    chk(n_fc, n_osc);
    chk(n_edge, 0);
    chk(32'({sensor_clk_oe, sensor_clk}), 32'h0);
    wr(scmc_pkg::ADDR_MODE, 8'h17);
    chk(32'(op_mode), 32'(scmc_pkg::MODE_INT));
    wr(scmc_pkg::ADDR_MODE, 8'h10);
    window();
    chk(n_fc, n_bc);
    wr(scmc_pkg::ADDR_MODE, 8'h15);
    chk(32'(op_mode), 32'(scmc_pkg::MODE_COMPAT));
    chk(32'(parallel_compat_mode), 32'h1);
    window();
    chk(n_fc, n_ext);
  endtask

  task automatic t_compat;
    wr(scmc_pkg::ADDR_FMT, 8'h03);
    chk(32'(compat_raw12), 32'h1);
    pkt(scmc_pkg::DT_RAW12, 1'b1);
    pkt(scmc_pkg::DT_RAW10, 1'b0);
    wr(scmc_pkg::ADDR_FMT, 8'h00);
    chk(32'(compat_raw12), 32'h0);
    rd(scmc_pkg::ADDR_FMT, 8'h00);
    wr(scmc_pkg::ADDR_FMT, 8'h01);
    chk(32'(compat_raw12), 32'h0);
    pkt(scmc_pkg::DT_RAW10, 1'b1);
    pkt(scmc_pkg::DT_RAW12, 1'b0);
    pkt(6'h2A, 1'b0);
    wr(scmc_pkg::ADDR_PTYPE, 8'h2A);
    wr(scmc_pkg::ADDR_PCFG, 8'h04);
    rd(scmc_pkg::ADDR_PTYPE, 8'h2A);
    pkt(6'h2A, 1'b1);
    pkt(6'h2A, 1'b1);
    wr(scmc_pkg::ADDR_FMT, 8'h03);
    pkt(6'h2A, 1'b1);
    wr(scmc_pkg::ADDR_PCFG, 8'h02);
    rd(scmc_pkg::ADDR_PCFG, 8'h02);
    pkt(6'h1A, 1'b1);
    pkt(6'h30, 1'b0);
    wr(scmc_pkg::ADDR_PCFG, 8'h01);
    pkt(6'h30, 1'b1);
    pkt(6'h05, 1'b0);
    rd(8'h20, 8'h00);
  endtask

  task automatic results;
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rd(scmc_pkg::ADDR_MODE, 8'h00);
    t_sensor();
    t_rate();
    t_clkcfg();
    t_strap();
    t_override();
    t_compat();
    results();
  end
endmodule
